// ===== pmc_clock_mgmt.sv
`timescale 1ns/1ps
// Behaviour
// (R01) oscillator runs 20 MHz until retuned
// (R02) pre regulator uses slow or fast clock
// (R03) both bucks use the fast clock
// (R04) each clock delayable 1-7 internal cycles
// (R05) three 3-bit shift fields, one per regulator
// (R06) pre and aux edge starts high-side
// (R07) core edge starts low-side on-time
// (R08) oscillator tunable 16-24 MHz, 1 MHz steps
// (R09) host steps one code, 10 us apart
// (R10) tune code map, resets to zero
// (R11) undefined tune codes give 20 MHz
// (R12) triangular 23/94 kHz carrier, plus minus 5%
// (R13) spread enable and carrier bits, default off
// (R14) host never combines spread with tuning
// (R15) host picks carrier matching pre clock
// (R16) external sync needs the pll enable bit
// (R17) host keeps sync input in range
// (R18) divider keeps pll output 16-24 MHz
// (R19) select moves internal clock to external
// (R20) host programs divider, clock, then select
// (R21) out of range falls back, flags error
// (R22) host repeats sequence after recovery
// (R23) 4-bit field selects sync output clock
// (R24) output mux code map, default low
module pmc_clock_mgmt
   import pmc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [3:0] osc_tune_code,
   input  wire logic       spread_enable,
   input  wire logic       spread_carrier_select,
   input  wire logic       pre_reg_fast_select,
   input  wire logic       swclk_out_fast_select,
   input  wire logic [2:0] pre_reg_phase_shift,
   input  wire logic [2:0] core_buck_phase_shift,
   input  wire logic [2:0] aux_buck_phase_shift,
   input  wire logic       pll_use_otp,
   input  wire logic       sync_input_divider,
   input  wire logic       external_sync_select,
   input  wire logic [3:0] sync_out_select,
   input  wire logic       sync_in_pin,
   output logic            internal_clk_tick,
   output logic            ext_clock_active,
   output logic            sync_in_range_flag,
   output logic            pre_reg_clk,
   output logic            core_buck_clk,
   output logic            aux_buck_clk,
   output logic            pre_reg_hs_on,
   output logic            core_buck_ls_on,
   output logic            aux_buck_hs_on,
   output logic            divided_sync_clock,
   output logic            sync_out_pin
);

   // ----------------------------------------------------------------
   // tune code and output select registered every cycle, defaults loaded at reset
   // ----------------------------------------------------------------
   logic [3:0]       tune_r;
   logic [3:0]       out_sel_r;
   logic [ACC_W-1:0] base_inc_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tune_r    <= TUNE_DEFAULT; // [R10] [R01]
         out_sel_r <= OUT_LOW;      // [R24]
      end else begin
         tune_r    <= osc_tune_code;
         out_sel_r <= sync_out_select; // [R23]
      end
   end

   // tune code to phase increment; unused codes fall to default
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         base_inc_r <= pmc_inc(OSC_DEF_KHZ);
      end else if (tune_r >= TUNE_UP_FIRST && tune_r <= TUNE_UP_LAST) begin
         base_inc_r <= pmc_inc(OSC_DEF_KHZ + OSC_STEP_KHZ * int'(tune_r)); // [R08] [R10]
      end else if (tune_r >= TUNE_DN_FIRST && tune_r <= TUNE_DN_LAST) begin
         base_inc_r <= pmc_inc(OSC_MIN_KHZ
                               + OSC_STEP_KHZ * int'(tune_r - TUNE_DN_FIRST)); // [R08] [R10]
      end else begin
         base_inc_r <= pmc_inc(OSC_DEF_KHZ); // [R11]
      end
   end

   // ----------------------------------------------------------------
   // spread spectrum triangle
   // ----------------------------------------------------------------
   logic [SS_CNT_W-1:0] ss_cnt_r;
   logic [7:0]          tri_r;
   logic                tri_up_r;
   logic [SS_CNT_W-1:0] ss_limit;
   logic [ACC_W-1:0]    osc_inc;
   logic [47:0]         inc_lo;
   logic [47:0]         inc_span;

   assign ss_limit = spread_carrier_select ? SS_CNT_W'(SS_HIGH_CYC - 1)
                                           : SS_CNT_W'(SS_LOW_CYC - 1); // [R12] [R13]

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ss_cnt_r <= '0;
         tri_r    <= 8'h80;
         tri_up_r <= 1'b1;
      end else if (!spread_enable) begin
         ss_cnt_r <= '0;
         tri_r    <= 8'h80;
         tri_up_r <= 1'b1;
      end else if (ss_cnt_r >= ss_limit) begin
         ss_cnt_r <= '0;
         if (tri_up_r) begin
            tri_r    <= tri_r + 8'h01;
            tri_up_r <= (tri_r != 8'hFE);
         end else begin
            tri_r    <= tri_r - 8'h01;
            tri_up_r <= (tri_r == 8'h01);
         end
      end else begin
         ss_cnt_r <= ss_cnt_r + SS_CNT_W'(1);
      end
   end

   always_comb begin
      inc_lo   = 48'(base_inc_r) * 48'(100 - SS_DEV_PCT) / 48'd100;
      inc_span = 48'(base_inc_r) * 48'(2 * SS_DEV_PCT) / 48'd100;
      if (spread_enable) begin
         osc_inc = ACC_W'(inc_lo + inc_span * 48'(tri_r) / 48'(TRI_MAX)); // [R12]
      end else begin
         osc_inc = base_inc_r; // [R13]
      end
   end

   // ----------------------------------------------------------------
   // main and safety oscillators as tick generators
   // ----------------------------------------------------------------
   logic [ACC_W-1:0] osc_acc_r;
   logic [ACC_W-1:0] safe_acc_r;
   logic             osc_tick_r;
   logic             safe_tick_r;
   logic [ACC_W:0]   osc_sum;
   logic [ACC_W:0]   safe_sum;

   assign osc_sum  = {1'b0, osc_acc_r} + {1'b0, osc_inc};
   assign safe_sum = {1'b0, safe_acc_r} + {1'b0, pmc_inc(SAFE_OSC_KHZ)};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_acc_r  <= '0;
         osc_tick_r <= 1'b0;
      end else begin
         osc_acc_r  <= osc_sum[ACC_W-1:0];
         osc_tick_r <= osc_sum[ACC_W];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         safe_acc_r  <= '0;
         safe_tick_r <= 1'b0;
      end else begin
         safe_acc_r  <= safe_sum[ACC_W-1:0];
         safe_tick_r <= safe_sum[ACC_W];
      end
   end

   // ----------------------------------------------------------------
   // sync input capture and pre-divider
   // ----------------------------------------------------------------
   logic       sin_s1_r;
   logic       sin_s2_r;
   logic       sin_s3_r;
   logic [1:0] div_cnt_r;
   logic       dsync_prev_r;
   logic       dsync_edge;
   logic       sin_rise;

   assign sin_rise = sin_s2_r & ~sin_s3_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sin_s1_r <= 1'b0;
         sin_s2_r <= 1'b0;
         sin_s3_r <= 1'b0;
      end else begin
         sin_s1_r <= sync_in_pin;
         sin_s2_r <= sin_s1_r;
         sin_s3_r <= sin_s2_r;
      end
   end

   // divide by six in the fast input range keeps the pll output in band
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt_r          <= '0;
         divided_sync_clock <= 1'b0;
      end else if (!sync_input_divider) begin
         div_cnt_r          <= '0;
         divided_sync_clock <= sin_s2_r;
      end else if (sin_rise) begin
         if (div_cnt_r == 2'(FAST_IN_DIV / 2 - 1)) begin
            div_cnt_r          <= '0;
            divided_sync_clock <= ~divided_sync_clock; // [R18]
         end else begin
            div_cnt_r <= div_cnt_r + 2'd1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dsync_prev_r <= 1'b0;
      end else begin
         dsync_prev_r <= divided_sync_clock;
      end
   end

   assign dsync_edge = divided_sync_clock & ~dsync_prev_r;

   // ----------------------------------------------------------------
   // range monitor and pll multiplier
   // ----------------------------------------------------------------
   logic [PER_W-1:0] sync_period;
   logic [PER_W:0]   pll_acc_r;
   logic             pll_tick_r;
   logic [PER_W:0]   pll_sum;

   pmc_range_mon u_range (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .edge_in  (dsync_edge),
      .in_range (sync_in_range_flag), // [R21]
      .period   (sync_period)
   );

   assign pll_sum = pll_acc_r + (PER_W + 1)'(PLL_MULT);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pll_acc_r  <= '0;
         pll_tick_r <= 1'b0;
      end else if (pll_sum >= {1'b0, sync_period}) begin
         pll_acc_r  <= pll_sum - {1'b0, sync_period}; // [R18]
         pll_tick_r <= 1'b1;
      end else begin
         pll_acc_r  <= pll_sum;
         pll_tick_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // internal clock source selection
   // ----------------------------------------------------------------
   logic ext_sel_prev_r;
   logic ext_armed_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_sel_prev_r <= 1'b0;
      end else begin
         ext_sel_prev_r <= external_sync_select;
      end
   end

   // a fault drops the arm; only a fresh select edge re-arms
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_armed_r <= 1'b0;
      end else if (!external_sync_select || !pll_use_otp) begin
         ext_armed_r <= 1'b0; // [R16]
      end else if (ext_clock_active && !sync_in_range_flag) begin
         ext_armed_r <= 1'b0; // [R21] [R22]
      end else if (!ext_sel_prev_r) begin
         ext_armed_r <= 1'b1; // [R19] [R20]
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_clock_active <= 1'b0;
      end else begin
         ext_clock_active <= ext_armed_r && sync_in_range_flag && pll_use_otp
                             && !(ext_clock_active && !sync_in_range_flag); // [R19] [R16]
      end
   end

   assign internal_clk_tick = ext_clock_active ? pll_tick_r : osc_tick_r; // [R19] [R21]

   // ----------------------------------------------------------------
   // switching clock dividers
   // ----------------------------------------------------------------
   logic [SW_CNT_W-1:0] fast_cnt_r;
   logic [SW_CNT_W-1:0] slow_cnt_r;
   logic                fast_clk_r;
   logic                slow_clk_r;
   logic                pre_src;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fast_cnt_r <= '0;
         fast_clk_r <= 1'b0;
      end else if (internal_clk_tick) begin
         fast_cnt_r <= (fast_cnt_r == SW_CNT_W'(FAST_DIV - 1)) ? '0
                                                              : fast_cnt_r + SW_CNT_W'(1);
         fast_clk_r <= (fast_cnt_r < SW_CNT_W'(FAST_DIV / 2)) ||
                       (fast_cnt_r == SW_CNT_W'(FAST_DIV - 1));
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slow_cnt_r <= '0;
         slow_clk_r <= 1'b0;
      end else if (internal_clk_tick) begin
         slow_cnt_r <= (slow_cnt_r == SW_CNT_W'(SLOW_DIV - 1)) ? '0
                                                              : slow_cnt_r + SW_CNT_W'(1);
         slow_clk_r <= (slow_cnt_r < SW_CNT_W'(SLOW_DIV / 2)) ||
                       (slow_cnt_r == SW_CNT_W'(SLOW_DIV - 1));
      end
   end

   assign pre_src = pre_reg_fast_select ? fast_clk_r : slow_clk_r; // [R02]

   // ----------------------------------------------------------------
   // per regulator phase shift
   // ----------------------------------------------------------------
   pmc_phase_shift u_pre_shift (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (internal_clk_tick),
      .clk_in  (pre_src),
      .shift   (pre_reg_phase_shift), // [R04] [R05]
      .clk_out (pre_reg_clk),
      .rise    (pre_reg_hs_on)        // [R06]
   );

   pmc_phase_shift u_core_shift (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (internal_clk_tick),
      .clk_in  (fast_clk_r),          // [R03]
      .shift   (core_buck_phase_shift), // [R04] [R05]
      .clk_out (core_buck_clk),
      .rise    (core_buck_ls_on)      // [R07]
   );

   pmc_phase_shift u_aux_shift (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (internal_clk_tick),
      .clk_in  (fast_clk_r),          // [R03]
      .shift   (aux_buck_phase_shift), // [R04] [R05]
      .clk_out (aux_buck_clk),
      .rise    (aux_buck_hs_on)       // [R06]
   );

   // ----------------------------------------------------------------
   // divide by 48 monitors
   // ----------------------------------------------------------------
   logic [4:0] main48_cnt_r;
   logic [4:0] safe48_cnt_r;
   logic       main48_r;
   logic       safe48_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         main48_cnt_r <= '0;
         main48_r     <= 1'b0;
      end else if (internal_clk_tick) begin
         if (main48_cnt_r == 5'(OUT_DIV_HALF - 1)) begin
            main48_cnt_r <= '0;
            main48_r     <= ~main48_r;
         end else begin
            main48_cnt_r <= main48_cnt_r + 5'd1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         safe48_cnt_r <= '0;
         safe48_r     <= 1'b0;
      end else if (safe_tick_r) begin
         if (safe48_cnt_r == 5'(OUT_DIV_HALF - 1)) begin
            safe48_cnt_r <= '0;
            safe48_r     <= ~safe48_r;
         end else begin
            safe48_cnt_r <= safe48_cnt_r + 5'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // sync output multiplexer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_out_pin <= 1'b0;
      end else begin
         case (out_sel_r) // [R23] [R24]
            OUT_PRE:    sync_out_pin <= pre_reg_clk;
            OUT_CORE:   sync_out_pin <= core_buck_clk;
            OUT_AUX:    sync_out_pin <= aux_buck_clk;
            OUT_SWCLK:  sync_out_pin <= swclk_out_fast_select ? fast_clk_r : slow_clk_r;
            OUT_OSC48:  sync_out_pin <= main48_r & pll_use_otp;
            OUT_SAFE48: sync_out_pin <= safe48_r;
            OUT_DSYNC:  sync_out_pin <= divided_sync_clock;
            default:    sync_out_pin <= 1'b0;
         endcase
      end
   end

endmodule : pmc_clock_mgmt

// ===== pmc_clock_mgmt_chk.sv
`timescale 1ns/1ps
module pmc_chk
   import pmc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       pll_use_otp,
   input wire logic       external_sync_select,
   input wire logic [3:0] sync_out_select,
   input wire logic       ext_clock_active,
   input wire logic       sync_in_range_flag,
   input wire logic       pre_reg_clk,
   input wire logic       core_buck_clk,
   input wire logic       aux_buck_clk,
   input wire logic       pre_reg_hs_on,
   input wire logic       core_buck_ls_on,
   input wire logic       aux_buck_hs_on,
   input wire logic       sync_out_pin
);
   // ----
   // port checks
   // ----
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_pre_hs; $rose(pre_reg_clk) |=> pre_reg_hs_on ##1 !pre_reg_hs_on; endproperty
   a_pre_hs: assert property (p_pre_hs) else $error("pre start bad");
   property p_aux_hs; $rose(aux_buck_clk) |=> aux_buck_hs_on ##1 !aux_buck_hs_on; endproperty
   a_aux_hs: assert property (p_aux_hs) else $error("aux start bad");
   property p_core_ls; $rose(core_buck_clk) |=> core_buck_ls_on; endproperty
   a_core_ls: assert property (p_core_ls) else $error("core start bad");
   property p_mux_low;
      (sync_out_select inside {4'h0, 4'h2, 4'h4} || sync_out_select > 4'h9)[*2] |=> !sync_out_pin;
   endproperty
   a_mux_low: assert property (p_mux_low) else $error("out not low");
   property p_mux_pre;
      (sync_out_select == OUT_PRE)[*3] |=> sync_out_pin == $past(pre_reg_clk);
   endproperty
   a_mux_pre: assert property (p_mux_pre) else $error("out not pre");
   property p_fallback; !sync_in_range_flag |=> !ext_clock_active; endproperty
   a_fallback: assert property (p_fallback) else $error("no fallback");
   property p_pll_gate; ext_clock_active |-> pll_use_otp; endproperty
   a_pll_gate: assert property (p_pll_gate) else $error("ext without pll");
   property p_ext_sel;
      $rose(ext_clock_active) |-> $past(external_sync_select) && $past(sync_in_range_flag);
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("ext without select");
endmodule : pmc_chk

bind pmc_clock_mgmt pmc_chk chk_u (
   .sys_clk, .rst, .pll_use_otp, .external_sync_select, .sync_out_select,
   .ext_clock_active, .sync_in_range_flag, .pre_reg_clk, .core_buck_clk, .aux_buck_clk,
   .pre_reg_hs_on, .core_buck_ls_on, .aux_buck_hs_on, .sync_out_pin
);

// ===== pmc_clock_mgmt_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("BAD %0t mismatch", $time); end end
module pmc_clock_mgmt_tb;
   // ----
   // stimulus and monitors
   // ----
   logic       sys_clk = 1'h0, rst = 1'h1, run = 1'h0, spread_enable = 1'h0;
   logic       spread_carrier_select = 1'h0, pre_reg_fast_select = 1'h0;
   logic       pll_use_otp = 1'h0, external_sync_select = 1'h0, div = 1'h0, pp, po;
   logic [3:0] osc_tune_code = 4'h0, sync_out_select = 4'h0;
   logic [2:0] pre_reg_phase_shift = 3'h0, aux_buck_phase_shift = 3'h0;
   logic [11:0] half_ns = 12'h4E2;
   logic       sync_in_pin, internal_clk_tick, ext_clock_active, sync_in_range_flag;
   logic       pre_reg_clk, core_buck_clk, aux_buck_clk, pre_reg_hs_on, core_buck_ls_on;
   logic       aux_buck_hs_on, divided_sync_clock, sync_out_pin;
   int         n_mismatch = 0, comparisons = 0, gap = 0, mn, mx, nt, np, nf, d;
   localparam logic [15:0] ACT = 16'h03EA;
   logic [3:0] tune [14] = '{4'h5, 4'hF, 4'h1, 4'h2, 4'h3, 4'h4, 4'h3,
                             4'h2, 4'h1, 4'h0, 4'hC, 4'hB, 4'hA, 4'h9};
   always #2 sys_clk = ~sys_clk;
   pmc_clock_mgmt dut_u (.sys_clk, .rst, .osc_tune_code, .spread_enable,
      .spread_carrier_select, .pre_reg_fast_select, .swclk_out_fast_select(1'h0),
      .pre_reg_phase_shift, .core_buck_phase_shift(3'h0), .aux_buck_phase_shift,
      .pll_use_otp, .sync_input_divider(div), .external_sync_select, .sync_out_select,
      .sync_in_pin, .internal_clk_tick, .ext_clock_active, .sync_in_range_flag,
      .pre_reg_clk, .core_buck_clk, .aux_buck_clk, .pre_reg_hs_on, .core_buck_ls_on,
      .aux_buck_hs_on, .divided_sync_clock, .sync_out_pin);
   pmc_sync_src src_u (.run, .half_ns, .sync_in_pin);
   always @(posedge sys_clk) begin
      gap++;
      if (internal_clk_tick === 1'h1) begin
         mn = gap < mn ? gap : mn;
         mx = gap > mx ? gap : mx;
         nt++;
         gap = 0;
      end
      np += int'(pre_reg_clk === 1'h1 && pp === 1'h0);
      nf += int'(sync_out_pin !== po);
      pp = pre_reg_clk;
      po = sync_out_pin;
   end
   function automatic int khz(input logic [3:0] c);
      if (c <= 4'h4) return 20000 + c * 1000;
      if (c >= 4'h9 && c <= 4'hC) return 7000 + c * 1000;
      return 20000;
   endfunction : khz
   task automatic meas(input int n);
      repeat (50) @(negedge sys_clk);
      {mn, mx, nt, np, nf} = {32'h0000_0063, 128'h0};
      repeat (n) @(negedge sys_clk);
   endtask : meas
   task automatic lag(input logic s, output int r);
      logic pc, pb;
      r = -1;
      for (int t = 0; t < 400; t++) begin
         pc = core_buck_clk;
         pb = s ? pre_reg_clk : aux_buck_clk;
         @(negedge sys_clk);
         if (pc === 1'h0 && core_buck_clk === 1'h1) r = 0;
         else if (r >= 0) r++;
         if (r >= 0 && pb === 1'h0 && (s ? pre_reg_clk : aux_buck_clk) === 1'h1) break;
      end
   endtask : lag
   task automatic waitf(input logic v);
      for (int t = 0; sync_in_range_flag !== v; t++) begin
         @(negedge sys_clk);
         if (t > 5000) begin
            n_mismatch++;
            conclude();
         end
      end
   endtask : waitf
   task conclude;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      for (int c = 0; c < 3; c++) begin
         @(posedge sys_clk) spread_enable <= c > 0;
         {spread_carrier_select, pre_reg_fast_select} <= {2{c == 2}};
         meas(c > 0 ? 11000 : 3000);
         `CHK(mn * 100 + mx, c > 0 ? 1114 : 1213)
         if (c == 0) `CHK(np > 4 && np < 7 && nt > 238 && nt < 242, 1'h1)
      end
      @(posedge sys_clk) spread_enable <= 1'h0;
      pre_reg_fast_select <= 1'h1;
      for (int n = 0; n < 8; n++) begin
         @(posedge sys_clk) aux_buck_phase_shift <= n[2:0];
         pre_reg_phase_shift <= 3'h7 - n[2:0];
         repeat (300) @(posedge sys_clk);
         lag(1'h0, d);
         `CHK(d >= 12 * n && d <= 13 * n, 1'h1)
         lag(1'h1, d);
         `CHK(d >= 84 - 12 * n && d <= 91 - 13 * n, 1'h1)
      end
      @(posedge sys_clk) run <= 1'h1;
      waitf(1'h1);
      @(posedge sys_clk) external_sync_select <= 1'h1;
      repeat (20) @(posedge sys_clk);
      `CHK(ext_clock_active, 1'h0)
      pll_use_otp <= 1'h1;
      external_sync_select <= 1'h0;
      @(posedge sys_clk) external_sync_select <= 1'h1;
      meas(2500);
      `CHK(ext_clock_active === 1'h1 && nt > 189 && nt < 195, 1'h1)
      @(posedge sys_clk) half_ns <= 12'h1F4;
      waitf(1'h0);
      repeat (2) @(negedge sys_clk);
      `CHK(ext_clock_active, 1'h0)
      @(posedge sys_clk) {half_ns, div} <= 13'h0191;
      waitf(1'h1);
      for (int s = 0; s < 16; s++) begin
         @(posedge sys_clk) sync_out_select <= s[3:0];
         meas(700);
         `CHK(nf > 0, ACT[s])
      end
      `CHK(ext_clock_active, 1'h0)
      foreach (tune[i]) begin
         @(posedge sys_clk) osc_tune_code <= tune[i];
         meas(2500);
         `CHK(nt - khz(tune[i]) / 100 inside {-1, 0, 1}, 1'h1)
      end
      conclude();
   end
endmodule : pmc_clock_mgmt_tb

// ===== pmc_phase_shift.sv
`timescale 1ns/1ps
module pmc_phase_shift
   import pmc_pkg::*;
#(
   parameter int DEPTH = SHIFT_MAX
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       clk_in,
   input  wire logic [2:0] shift,
   output logic            clk_out,
   output logic            rise
);

   logic [DEPTH-1:0] line_r;
   logic             prev_r;

   // ----------------------------------------------------------------
   // delay line stepped by the internal clock
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_r <= '0;
      end else if (tick) begin
         line_r <= {line_r[DEPTH-2:0], clk_in};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_out <= 1'b0;
      end else if (shift == 3'd0) begin
         clk_out <= clk_in;
      end else begin
         clk_out <= line_r[shift - 3'd1];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_r <= 1'b0;
         rise   <= 1'b0;
      end else begin
         prev_r <= clk_out;
         rise   <= clk_out & ~prev_r;
      end
   end

endmodule : pmc_phase_shift

// ===== pmc_pkg.sv
package pmc_pkg;

   // ----------------------------------------------------------------
   // system timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_KHZ    = 250000;
   localparam int SYS_CLK_HZ     = 250000000;

   // ----------------------------------------------------------------
   // internal oscillator model
   // ----------------------------------------------------------------
   localparam int ACC_W          = 24;
   localparam int OSC_DEF_KHZ    = 20000;
   localparam int OSC_MIN_KHZ    = 16000;
   localparam int OSC_MAX_KHZ    = 24000;
   localparam int OSC_STEP_KHZ   = 1000;
   localparam int SAFE_OSC_KHZ   = 20000;
   localparam int PHASE_STEP_NS  = 50;

   localparam logic [3:0] TUNE_DEFAULT  = 4'h0;
   localparam logic [3:0] TUNE_UP_FIRST = 4'h1;
   localparam logic [3:0] TUNE_UP_LAST  = 4'h4;
   localparam logic [3:0] TUNE_DN_FIRST = 4'h9;
   localparam logic [3:0] TUNE_DN_LAST  = 4'hC;

   // ----------------------------------------------------------------
   // switching clock dividers, in internal clock cycles
   // ----------------------------------------------------------------
   localparam int FAST_SW_KHZ    = 2220;
   localparam int SLOW_SW_KHZ    = 455;
   localparam int FAST_DIV       = (OSC_DEF_KHZ + FAST_SW_KHZ / 2) / FAST_SW_KHZ;
   localparam int SLOW_DIV       = (OSC_DEF_KHZ + SLOW_SW_KHZ / 2) / SLOW_SW_KHZ;
   localparam int SW_CNT_W       = 6;
   localparam int SHIFT_MAX      = 7;
   localparam int OUT_DIV_HALF   = 24;

   // ----------------------------------------------------------------
   // spread spectrum
   // ----------------------------------------------------------------
   localparam int SS_LOW_HZ      = 23000;
   localparam int SS_HIGH_HZ     = 94000;
   localparam int SS_DEV_PCT     = 5;
   localparam int TRI_MAX        = 255;
   localparam int SS_LOW_CYC     = SYS_CLK_HZ / (SS_LOW_HZ * 2 * TRI_MAX);
   localparam int SS_HIGH_CYC    = SYS_CLK_HZ / (SS_HIGH_HZ * 2 * TRI_MAX);
   localparam int SS_CNT_W       = 8;

   // ----------------------------------------------------------------
   // external synchronisation
   // ----------------------------------------------------------------
   localparam int SYNC_MIN_KHZ   = 333;
   localparam int SYNC_MAX_KHZ   = 500;
   localparam int SYNC_PER_MIN   = SYS_CLK_KHZ / SYNC_MAX_KHZ;
   localparam int SYNC_PER_MAX   = (SYS_CLK_KHZ + SYNC_MIN_KHZ - 1) / SYNC_MIN_KHZ;
   localparam int PER_W          = 11;
   localparam int PLL_MULT       = 48;
   localparam int FAST_IN_DIV    = 6;

   // ----------------------------------------------------------------
   // sync output multiplexer codes
   // ----------------------------------------------------------------
   localparam logic [3:0] OUT_LOW      = 4'h0;
   localparam logic [3:0] OUT_PRE      = 4'h1;
   localparam logic [3:0] OUT_CORE     = 4'h3;
   localparam logic [3:0] OUT_AUX      = 4'h5;
   localparam logic [3:0] OUT_SWCLK    = 4'h6;
   localparam logic [3:0] OUT_OSC48    = 4'h7;
   localparam logic [3:0] OUT_SAFE48   = 4'h8;
   localparam logic [3:0] OUT_DSYNC    = 4'h9;

   // phase increment per system cycle for a tick rate in kHz
   function automatic logic [ACC_W-1:0] pmc_inc(input int khz);
      longint p;
      p = (longint'(khz) << ACC_W) / SYS_CLK_KHZ;
      return p[ACC_W-1:0];
   endfunction : pmc_inc

endpackage : pmc_pkg

// ===== pmc_range_mon.sv
`timescale 1ns/1ps
module pmc_range_mon
   import pmc_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             edge_in,
   output logic                  in_range,
   output logic [PER_W-1:0]      period
);

   localparam logic [PER_W-1:0] PMIN = PER_W'(SYNC_PER_MIN);
   localparam logic [PER_W-1:0] PMAX = PER_W'(SYNC_PER_MAX);

   logic [PER_W-1:0] cnt_r;

   // ----------------------------------------------------------------
   // period measurement, saturating just past the longest period
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (edge_in) begin
         cnt_r <= PER_W'(1);
      end else if (cnt_r <= PMAX) begin
         cnt_r <= cnt_r + PER_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         in_range <= 1'b0;
         period   <= PMAX;
      end else if (edge_in) begin
         in_range <= (cnt_r >= PMIN) && (cnt_r <= PMAX);
         period   <= cnt_r;
      end else if (cnt_r > PMAX) begin
         in_range <= 1'b0;
      end
   end

endmodule : pmc_range_mon

// ===== pmc_sync_src.sv
`timescale 1ns/1ps
module pmc_sync_src (
   input  wire logic        run,
   input  wire logic [11:0] half_ns,
   output logic             sync_in_pin
);
   // ----
   // external clock source
   // ----
   always begin
      if (run) begin
         #(half_ns) sync_in_pin = ~sync_in_pin;
      end else begin
         sync_in_pin = 1'h0; // pulled down while idle
         #1;
      end
   end
endmodule : pmc_sync_src
